// ===== design/flash_ctl_pkg.sv
// package: constants and carrier types for the parallel flash erase/poll controller
package flash_ctl_pkg;
    localparam int          ADDR_W          = 18;
    localparam int          DATA_W          = 8;
    localparam logic [17:0] UNLOCK_ADDR_A   = 18'h05555;
    localparam logic [17:0] UNLOCK_ADDR_B   = 18'h02AAA;
    localparam logic [7:0]  UNLOCK_DATA_A   = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA_B   = 8'h55;
    localparam logic [7:0]  ERASE_SETUP_CMD = 8'h80;
    localparam logic [7:0]  CHIP_ERASE_CMD  = 8'h10;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam int          POLL_BIT        = 7;
    localparam int          TOGGLE_BIT      = 6;
    localparam int          SEQ_LEN         = 6;
    // bus cycle timing at 250 MHz (4 ns)
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          WRITE_PULSE_NS  = 35;
    localparam int          WRITE_HIGH_NS   = 30;
    localparam int          READ_ACCESS_NS  = 90;
    localparam int          READ_HOLD_NS    = 10;
    localparam int          WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RA_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RH_CYC = (READ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // pin register, two filter stages and the accepted-byte register
    localparam int          SYNC_CYC        = 4;
    localparam logic [2:0]  STEP_RESET      = 3'h0;
    localparam logic [5:0]  CNT_RESET       = 6'h00;

    typedef enum logic [1:0] {
        MODE_ERASE,
        MODE_POLL_DATA,
        MODE_POLL_TOGGLE
    } op_mode_e;

    typedef enum {
        ST_IDLE,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_RD_ACCESS,
        ST_RD_HOLD,
        ST_DONE
    } phase_e;

    // pins toward the flash
    typedef struct packed {
        logic [17:0] addr;
        logic [7:0]  dout;
        logic        dout_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } flash_pins_s;

    // user command
    typedef struct packed {
        op_mode_e    mode;
        logic [17:0] addr;
        logic [7:0]  data;
    } cmd_s;
endpackage

// ===== design/flash_erase_ctl.sv
// host-side controller: chip erase command sequence and completion polling
`timescale 1ns/100ps
// Overview of operation
// - erase starts with AA@5555, 55@2AAA, 80@5555 as consecutive writes
// - then AA@5555, 55@2AAA, 10@5555; device starts erase on sixth write
// - keep reading status during erase; done only when byte reads all ones
// - program polling reads programmed address until poll bit equals written bit
// - toggle method compares toggle bit across two successive reads
module flash_erase_ctl
    import flash_ctl_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // user command
    input  wire logic        cmd_valid_in,
    input  wire cmd_s        cmd_in,
    output logic             cmd_ready_out,
    output logic             done_out,
    output logic [7:0]       last_read_out,
    // flash pins
    output logic [17:0]      flash_addr_out,
    output logic [7:0]       flash_data_out,
    output logic             flash_data_oe_out,
    input  wire logic [7:0]  flash_data_in,
    output logic             flash_ce_n_out,
    output logic             flash_oe_n_out,
    output logic             flash_we_n_out
);

    typedef struct packed {
        phase_e      phase;
        op_mode_e    mode;
        logic [2:0]  step;
        logic [5:0]  cnt;
        logic [17:0] addr;
        logic [7:0]  data;
        logic        have_prev;
        logic        prev_toggle;
        logic [7:0]  last_read;
        logic        done;
        logic        ready;
        logic        done_pulse;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [7:0]  sync3;
        logic [7:0]  din;
        flash_pins_s pins;
    } state_s;

    state_s st_q;
    state_s st_d;

    // fixed six-write unlock sequence for chip erase
    function automatic logic [25:0] erase_word(input logic [2:0] idx);
        case (idx)
            3'h0:    erase_word = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            3'h1:    erase_word = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
            3'h2:    erase_word = {UNLOCK_ADDR_A, ERASE_SETUP_CMD};
            3'h3:    erase_word = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            3'h4:    erase_word = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
            default: erase_word = {UNLOCK_ADDR_A, CHIP_ERASE_CMD};
        endcase
    endfunction

    function automatic flash_pins_s idle_pins();
        idle_pins      = '0;
        idle_pins.ce_n = 1'b1;
        idle_pins.oe_n = 1'b1;
        idle_pins.we_n = 1'b1;
    endfunction

    // pins follow the phase by one edge, so the full count keeps each strobe n cycles long
    function automatic logic [5:0] cyc(input int n);
        cyc = 6'(n);
    endfunction

    logic [25:0] word;

    always_comb
    begin
        st_d = st_q;
        word = erase_word(st_q.step);
        // data pins come from another timing domain: pin register, then two-stage agreement filter
        st_d.sync1 = flash_data_in;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        if (st_q.sync2 == st_q.sync3)
        begin
            st_d.din = st_q.sync3;
        end
        if (st_q.cnt != CNT_RESET)
        begin
            st_d.cnt = st_q.cnt - 6'h01;
        end
        case (st_q.phase)
            ST_IDLE:
            begin
                st_d.pins = idle_pins();
                if (cmd_valid_in)
                begin
                    st_d.mode      = cmd_in.mode;
                    st_d.addr      = cmd_in.addr;
                    st_d.data      = cmd_in.data;
                    st_d.step      = STEP_RESET;
                    st_d.have_prev = 1'b0;
                    st_d.done      = 1'b0;
                    if (cmd_in.mode == MODE_ERASE)
                    begin
                        st_d.phase = ST_WR_LOW;
                        st_d.cnt   = cyc(WP_CYC);
                    end
                    else
                    begin
                        st_d.phase = ST_RD_ACCESS;
                        // access time plus the four-cycle filter latency (pin register, two filter stages, accepted-byte register)
                        st_d.cnt   = cyc(RA_CYC + SYNC_CYC);
                    end
                end
            end
            ST_WR_LOW:
            begin
                st_d.pins.addr    = word[25:8];
                st_d.pins.dout    = word[7:0];
                st_d.pins.dout_oe = 1'b1;
                st_d.pins.ce_n    = 1'b0;
                st_d.pins.oe_n    = 1'b1;
                st_d.pins.we_n    = 1'b0;
                if (st_q.cnt == CNT_RESET)
                begin
                    st_d.pins.we_n = 1'b1;
                    st_d.phase     = ST_WR_HIGH;
                    st_d.cnt       = cyc(WH_CYC);
                end
            end
            ST_WR_HIGH:
            begin
                st_d.pins.ce_n = 1'b1;
                if (st_q.cnt == CNT_RESET)
                begin
                    st_d.pins.dout_oe = 1'b0;
                    if (st_q.step == 3'(SEQ_LEN - 1))
                    begin
                        // sixth write issued: erase runs, start status reads
                        st_d.phase = ST_RD_ACCESS;
                        st_d.addr  = UNLOCK_ADDR_A;
                        st_d.cnt   = cyc(RA_CYC + SYNC_CYC);
                    end
                    else
                    begin
                        st_d.step  = st_q.step + 3'h1;
                        st_d.phase = ST_WR_LOW;
                        st_d.cnt   = cyc(WP_CYC);
                    end
                end
            end
            ST_RD_ACCESS:
            begin
                st_d.pins.addr    = st_q.addr;
                st_d.pins.dout_oe = 1'b0;
                st_d.pins.ce_n    = 1'b0;
                st_d.pins.oe_n    = 1'b0;
                st_d.pins.we_n    = 1'b1;
                if (st_q.cnt == CNT_RESET)
                begin
                    st_d.last_read = st_q.din;
                    st_d.pins.oe_n = 1'b1;
                    st_d.pins.ce_n = 1'b1;
                    st_d.phase     = ST_RD_HOLD;
                    st_d.cnt       = cyc(RH_CYC);
                    case (st_q.mode)
                        MODE_ERASE:
                        begin
                            st_d.done = (st_q.din == ERASED_BYTE);
                        end
                        MODE_POLL_DATA:
                        begin
                            st_d.done = (st_q.din[POLL_BIT] == st_q.data[POLL_BIT]);
                        end
                        MODE_POLL_TOGGLE:
                        begin
                            // needs two reads; a steady bit means finished
                            st_d.done        = st_q.have_prev &&
                                               (st_q.din[TOGGLE_BIT] == st_q.prev_toggle);
                            st_d.prev_toggle = st_q.din[TOGGLE_BIT];
                            st_d.have_prev   = 1'b1;
                        end
                        default:
                        begin
                            st_d.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_RD_HOLD:
            begin
                // hold gap gives the toggle/poll status a fresh read cycle
                if (st_q.cnt == CNT_RESET)
                begin
                    if (st_q.done)
                    begin
                        st_d.phase = ST_DONE;
                    end
                    else
                    begin
                        st_d.phase = ST_RD_ACCESS;
                        st_d.cnt   = cyc(RA_CYC + SYNC_CYC);
                    end
                end
            end
            ST_DONE:
            begin
                st_d.pins  = idle_pins();
                st_d.done  = 1'b0;
                st_d.phase = ST_IDLE;
            end
            default:
            begin
                st_d.phase = ST_IDLE;
            end
        endcase
        // handshake outputs registered from the next phase
        st_d.ready      = (st_d.phase == ST_IDLE);
        st_d.done_pulse = (st_d.phase == ST_DONE);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            st_q       <= '0;
            st_q.phase <= ST_IDLE;
            st_q.pins  <= idle_pins();
            st_q.ready <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign cmd_ready_out     = st_q.ready;
    assign done_out          = st_q.done_pulse;
    assign last_read_out     = st_q.last_read;
    assign flash_addr_out    = st_q.pins.addr;
    assign flash_data_out    = st_q.pins.dout;
    assign flash_data_oe_out = st_q.pins.dout_oe;
    assign flash_ce_n_out    = st_q.pins.ce_n;
    assign flash_oe_n_out    = st_q.pins.oe_n;
    assign flash_we_n_out    = st_q.pins.we_n;

endmodule // flash_erase_ctl

// ===== verif/flash_dev_model.sv
// flash device model: erase decode, busy status reads, array data
`timescale 1ns/100ps
module flash_dev_model
    import flash_ctl_pkg::*;
#(
    parameter int BUSY_READS = 4
)(
    input  wire logic        clk_in,
    input  wire logic [17:0] addr_in,
    input  wire logic [7:0]  data_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        prog_go_in,
    input  wire logic [7:0]  prog_data_in,
    output logic [7:0]       data_out
);
    logic [7:0] seq_d [6];
    logic [7:0] rd_val, pd_q = 8'h00, last_q = 8'h00;
    logic       hit, we_q = 1'b1, oe_q = 1'b1, tog_q = 1'b0, prog_q = 1'b0, ers_q = 1'b0;
    int         step_q = 0, busy_q = 0;
    initial seq_d = '{UNLOCK_DATA_A, UNLOCK_DATA_B, ERASE_SETUP_CMD,
                      UNLOCK_DATA_A, UNLOCK_DATA_B, CHIP_ERASE_CMD};
    assign hit = data_in == seq_d[step_q]
        && addr_in == (step_q % 3 == 1 ? UNLOCK_ADDR_B : UNLOCK_ADDR_A);
    always_comb
    begin
        if (busy_q > 0)
            rd_val = {prog_q ? ~pd_q[7] : 1'b0, tog_q, 6'h2A};
        else
            rd_val = prog_q ? pd_q : (ers_q ? ERASED_BYTE : 8'h00);
    end
    // released bus shows the inverse of the last byte, so stale data never passes
    assign data_out = (!ce_n_in && !oe_n_in) ? rd_val : ~last_q;
    always @(posedge clk_in)
    begin
        we_q <= we_n_in;
        oe_q <= oe_n_in;
        if (prog_go_in)
        begin
            pd_q   <= prog_data_in;
            prog_q <= 1'b1;
            busy_q <= BUSY_READS;
        end
        if (we_q && !we_n_in)
        begin
            step_q <= (hit && step_q < SEQ_LEN - 1) ? step_q + 1 : 0;
            if (hit && step_q == SEQ_LEN - 1)
            begin
                busy_q <= BUSY_READS;
                prog_q <= 1'b0;
                ers_q  <= 1'b1;
            end
        end
        if (oe_n_in && !oe_q)
        begin
            last_q <= rd_val;
            if (busy_q > 0)
            begin
                busy_q <= busy_q - 1;
                tog_q  <= ~tog_q;
            end
        end
    end
endmodule // flash_dev_model

// ===== verif/flash_erase_ctl_properties.sv
// checker: port properties of the flash erase controller
`timescale 1ns/100ps
module flash_erase_ctl_properties
    import flash_ctl_pkg::*;
(
    // controller ports
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        cmd_valid_in,
    input wire cmd_s        cmd_in,
    input wire logic        cmd_ready_out,
    input wire logic        done_out,
    input wire logic [7:0]  last_read_out,
    input wire logic [17:0] flash_addr_out,
    input wire logic [7:0]  flash_data_out,
    input wire logic        flash_data_oe_out,
    input wire logic [7:0]  flash_data_in,
    input wire logic        flash_ce_n_out,
    input wire logic        flash_oe_n_out,
    input wire logic        flash_we_n_out
);
    op_mode_e   mode_q;
    logic [7:0] data_q;
    logic [3:0] rd_q;
    // reads since the command was taken, saturating
    always_ff @(posedge ref_clk_in)
    begin
        if (cmd_valid_in && cmd_ready_out)
        begin
            mode_q <= cmd_in.mode;
            data_q <= cmd_in.data;
            rd_q   <= 4'h0;
        end
        else if ($fell(flash_oe_n_out) && rd_q != 4'hF)
            rd_q <= rd_q + 4'h1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_take; cmd_valid_in && cmd_ready_out && cmd_in.mode == MODE_ERASE; endsequence
    sequence s_wr1; !flash_we_n_out && flash_addr_out == UNLOCK_ADDR_A
        && flash_data_out == UNLOCK_DATA_A; endsequence
    property p_wr1; s_take |-> ##[1:2] s_wr1; endproperty
    property p_wr_addr; $fell(flash_we_n_out) |-> flash_addr_out ==
        (flash_data_out == UNLOCK_DATA_B ? UNLOCK_ADDR_B : UNLOCK_ADDR_A); endproperty
    property p_erase; done_out && mode_q == MODE_ERASE |-> last_read_out == ERASED_BYTE;
    endproperty
    property p_poll; done_out && mode_q == MODE_POLL_DATA |->
        last_read_out[POLL_BIT] == data_q[POLL_BIT]; endproperty
    property p_tog; done_out && mode_q == MODE_POLL_TOGGLE |-> rd_q >= 4'h2; endproperty
    property p_wr_drive; !flash_we_n_out |->
        flash_data_oe_out && !flash_ce_n_out && flash_oe_n_out; endproperty
    property p_rd_float; !flash_oe_n_out |->
        !flash_data_oe_out && !flash_ce_n_out && flash_we_n_out; endproperty
    a_wr1: assert property (p_wr1) else $error("bad first write");
    a_wr_addr: assert property (p_wr_addr) else $error("bad write address");
    a_erase: assert property (p_erase) else $error("erase done early");
    a_poll: assert property (p_poll) else $error("poll done early");
    a_tog: assert property (p_tog) else $error("toggle done early");
    a_wr_drive: assert property (p_wr_drive) else $error("write strobe without drive");
    a_rd_float: assert property (p_rd_float) else $error("read strobe while driving");
endmodule // flash_erase_ctl_properties

// ===== verif/testbench.sv
// testbench: chip erase, data poll and toggle poll against the flash model
`timescale 1ns/100ps
module testbench;
    import flash_ctl_pkg::*;
    localparam int BUSY = 4;
    // bit 6 clear so the first array read differs from the last busy toggle read
    localparam logic [7:0] PROG_BYTE = 8'h1A;
    logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, cmd_valid_in = 1'b0, prog_go = 1'b0;
    cmd_s        cmd_in = '0;
    logic        cmd_ready_out, done_out, flash_data_oe_out, we_q = 1'b1, oe_q = 1'b1;
    logic        flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
    logic [7:0]  last_read_out, flash_data_out, flash_data_in;
    logic [17:0] flash_addr_out;
    logic [17:0] wa [$], ra [$];
    logic [7:0]  wd [$];
    int          n_mismatch = 0, check_count = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    flash_erase_ctl i_flash_erase_ctl (.ref_clk_in, .sys_rst_in, .cmd_valid_in, .cmd_in,
        .cmd_ready_out, .done_out, .last_read_out, .flash_addr_out, .flash_data_out,
        .flash_data_oe_out, .flash_data_in, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out);
    flash_dev_model #(.BUSY_READS(BUSY)) i_flash_dev_model (.clk_in(ref_clk_in),
        .addr_in(flash_addr_out), .data_in(flash_data_out), .ce_n_in(flash_ce_n_out),
        .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .prog_go_in(prog_go),
        .prog_data_in(PROG_BYTE), .data_out(flash_data_in));
    // log every write and read strobe with its address
    always @(posedge ref_clk_in)
    begin
        we_q <= flash_we_n_out;
        oe_q <= flash_oe_n_out;
        if (we_q && !flash_we_n_out)
        begin
            wa.push_back(flash_addr_out);
            wd.push_back(flash_data_out);
        end
        if (oe_q && !flash_oe_n_out)
            ra.push_back(flash_addr_out);
    end
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic run_cmd(input op_mode_e m, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wa.delete();
        wd.delete();
        ra.delete();
        cmd_in = '{m, a, d};
        cmd_valid_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        cmd_valid_in = 1'b0;
        while (done_out !== 1'b1 && n < 4000)
        begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        check(done_out, "no done pulse");
    endtask
    task automatic t_erase();
        logic [17:0] ea [6];
        logic [7:0]  ed [6];
        ea = '{UNLOCK_ADDR_A, UNLOCK_ADDR_B, UNLOCK_ADDR_A,
               UNLOCK_ADDR_A, UNLOCK_ADDR_B, UNLOCK_ADDR_A};
        ed = '{UNLOCK_DATA_A, UNLOCK_DATA_B, ERASE_SETUP_CMD,
               UNLOCK_DATA_A, UNLOCK_DATA_B, CHIP_ERASE_CMD};
        run_cmd(MODE_ERASE, 18'h00000, 8'h00);
        check(wa.size() == SEQ_LEN, "write count");
        foreach (ea[i]) check(wa[i] === ea[i] && wd[i] === ed[i], "command write");
        check(ra.size() == BUSY + 1 && last_read_out === ERASED_BYTE, "erase poll");
    endtask
    task automatic t_poll(input op_mode_e m, input logic [17:0] a, input int reads);
        prog_go = 1'b1;
        @(posedge ref_clk_in);
        #1;
        prog_go = 1'b0;
        run_cmd(m, a, PROG_BYTE);
        check(ra.size() == reads && last_read_out === PROG_BYTE, "poll end");
        foreach (ra[i]) check(ra[i] === a, "poll address");
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #20000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        #1;
        sys_rst_in = 1'b0;
        check(cmd_ready_out === 1'b1 && flash_we_n_out === 1'b1, "reset state");
        t_erase();
        t_poll(MODE_POLL_DATA, 18'h01234, BUSY + 1);
        t_poll(MODE_POLL_TOGGLE, 18'h1ABCD, BUSY + 2);
        close_out();
    end
endmodule // testbench
bind flash_erase_ctl flash_erase_ctl_properties i_flash_erase_ctl_properties (.ref_clk_in,
    .sys_rst_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .done_out, .last_read_out,
    .flash_addr_out, .flash_data_out, .flash_data_oe_out, .flash_data_in, .flash_ce_n_out,
    .flash_oe_n_out, .flash_we_n_out);
